//--- hdl/ifr_pkg.sv
// constants and types for the input overvoltage fault responder
// assumes a pmbus command decoder outside that hands over byte writes
package ifr_pkg;
  localparam logic [7:0] IFR_ACTION_ADDR = 8'h56; // command code of the action byte
  localparam logic [7:0] IFR_ACTION_RST  = 8'h80; // shut down, no retry, one unit
  localparam int         IFR_MODE_POS    = 6;     // response mode field 7:6
  localparam int         IFR_RETRY_POS   = 3;     // retry field 5:3
  localparam int         IFR_DELAY_POS   = 0;     // delay field 2:0
  localparam logic [1:0] IFR_MODE_IGNORE = 2'h0;
  localparam logic [1:0] IFR_MODE_DELAY  = 2'h1;
  localparam logic [1:0] IFR_MODE_RETRY  = 2'h2;
  localparam logic [1:0] IFR_MODE_LATCH  = 2'h3;
  localparam logic [2:0] IFR_RETRY_NONE  = 3'h0;
  localparam logic [2:0] IFR_RETRY_CONT  = 3'h7; // restart without limit
  localparam logic [7:0] IFR_UNIT_ONE    = 8'h01;

  // action byte as stored
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] retries;
    logic [2:0] delay;
  } ifr_cfg_t;

  typedef enum logic [1:0] {
    IFR_RUN,
    IFR_DELAY,
    IFR_RETRY,
    IFR_LATCHED
  } ifr_state_t;
endpackage : ifr_pkg

//--- hdl/ifr_top.sv
// input overvoltage fault responder: action byte, delay timer, retry sequencer
// assumes fault, unit tick, clear and on command come from logic on SYS_CLK_IN
`timescale 1ns/100ps

module ifr_top
  import ifr_pkg::*;
(
  // clock and reset
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RST_N_IN,
  // pmbus byte port
  input  wire logic [7:0] CMD_CODE_IN,
  input  wire logic       WR_STB_IN,
  input  wire logic [7:0] WR_DATA_IN,
  output logic      [7:0] RD_DATA_OUT,
  // fault and control
  input  wire logic       FAULT_IN,
  input  wire logic       UNIT_TICK_IN,
  input  wire logic       CLEAR_IN,
  input  wire logic       ON_CMD_IN,
  // status
  output logic            OUT_EN_OUT,
  output logic            FAULT_LATCHED_OUT
);

  ifr_cfg_t   cfg_ff;
  ifr_state_t state_ff;
  ifr_state_t nxt_state;
  logic [2:0] attempts_ff;
  logic [2:0] nxt_attempts;
  logic       try_on_ff;
  logic       nxt_try_on;
  logic       fail_ff;
  logic       nxt_fail;
  logic [7:0] unit_cnt_ff;
  logic [7:0] delay_units;
  logic       timer_done;
  logic       timer_restart;
  logic       on_prev_ff;
  logic       clear_evt;
  logic       fault_act;
  logic       nxt_out_en;

  // action byte write and read path
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      cfg_ff <= ifr_cfg_t'(IFR_ACTION_RST);
    else if (WR_STB_IN && CMD_CODE_IN == IFR_ACTION_ADDR)
      cfg_ff <= ifr_cfg_t'(WR_DATA_IN);
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      RD_DATA_OUT <= 8'h00;
    else if (CMD_CODE_IN == IFR_ACTION_ADDR)
      RD_DATA_OUT <= cfg_ff;
    else
      RD_DATA_OUT <= 8'h00;
  end

  // clear events: explicit clear or off-to-on command edge
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      on_prev_ff <= 1'b0;
    else
      on_prev_ff <= ON_CMD_IN;
  end

  assign clear_evt = CLEAR_IN || (ON_CMD_IN && !on_prev_ff);

  // delay timer counts 2^delay unit ticks
  assign delay_units = IFR_UNIT_ONE << cfg_ff.delay;
  assign timer_done  = UNIT_TICK_IN && (unit_cnt_ff == delay_units - IFR_UNIT_ONE);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      unit_cnt_ff <= 8'h00;
    else if (timer_restart)
      unit_cnt_ff <= 8'h00;
    else if (UNIT_TICK_IN)
      unit_cnt_ff <= unit_cnt_ff + IFR_UNIT_ONE;
  end

  assign fault_act = FAULT_IN && cfg_ff.mode != IFR_MODE_IGNORE;

  // response sequencer
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_attempts  = attempts_ff;
    nxt_try_on    = try_on_ff;
    nxt_fail      = fail_ff;
    timer_restart = 1'b0;
    if (!ON_CMD_IN || clear_evt)
    begin
      // commanded off or cleared: idle and rearm
      nxt_state     = IFR_RUN;
      nxt_attempts  = cfg_ff.retries;
      nxt_try_on    = 1'b0;
      nxt_fail      = 1'b0;
      timer_restart = 1'b1;
    end
    else
    begin
      unique case (state_ff)
        IFR_RUN:
        begin
          timer_restart = 1'b1;
          if (fault_act)
          begin
            unique case (cfg_ff.mode)
              IFR_MODE_DELAY: nxt_state = IFR_DELAY;
              IFR_MODE_LATCH: nxt_state = IFR_LATCHED;
              default:
                nxt_state = (cfg_ff.retries == IFR_RETRY_NONE) ? IFR_LATCHED
                                                               : IFR_RETRY;
            endcase
            nxt_try_on   = 1'b0;
            nxt_attempts = cfg_ff.retries; // each fault starts from the current field
          end
        end
        IFR_DELAY:
        begin
          if (timer_done)
          begin
            timer_restart = 1'b1;
            if (!FAULT_IN)
              nxt_state = IFR_RUN;
            else if (cfg_ff.retries == IFR_RETRY_NONE)
              nxt_state = IFR_LATCHED;
            else
              nxt_state = IFR_RETRY;
          end
        end
        IFR_RETRY:
        begin
          if (timer_done)
          begin
            timer_restart = 1'b1;
            if (try_on_ff && !fail_ff && !FAULT_IN)
            begin
              nxt_state    = IFR_RUN; // attempt held up
              nxt_attempts = cfg_ff.retries;
            end
            else if (attempts_ff != 3'h0 || cfg_ff.retries == IFR_RETRY_CONT)
            begin
              nxt_try_on = 1'b1;
              nxt_fail   = 1'b0;
              if (cfg_ff.retries != IFR_RETRY_CONT)
                nxt_attempts = attempts_ff - 3'h1;
            end
            else
              nxt_state = IFR_LATCHED;
          end
          else if (try_on_ff && FAULT_IN)
            nxt_fail = 1'b1; // failed attempt turns off at once
        end
        IFR_LATCHED: nxt_state = IFR_LATCHED;
      endcase
    end
  end

  assign nxt_out_en = ON_CMD_IN && (nxt_state == IFR_RUN || nxt_state == IFR_DELAY ||
                      (nxt_state == IFR_RETRY && nxt_try_on && !nxt_fail));

  // sequencer state
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_ff    <= IFR_RUN;
      attempts_ff <= 3'h0;
      try_on_ff   <= 1'b0;
      fail_ff     <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      attempts_ff <= nxt_attempts;
      try_on_ff   <= nxt_try_on;
      fail_ff     <= nxt_fail;
    end
  end

  // registered outputs
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      OUT_EN_OUT        <= 1'b0;
      FAULT_LATCHED_OUT <= 1'b0;
    end
    else
    begin
      OUT_EN_OUT        <= nxt_out_en;
      FAULT_LATCHED_OUT <= (nxt_state == IFR_LATCHED);
    end
  end

  // checks
  property p_cfg_write;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (WR_STB_IN && CMD_CODE_IN == IFR_ACTION_ADDR) |=> (cfg_ff == $past(WR_DATA_IN));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("action byte not stored");

  property p_ignore;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == IFR_RUN && cfg_ff.mode == IFR_MODE_IGNORE && ON_CMD_IN && $past(ON_CMD_IN)
     && !WR_STB_IN) |=> OUT_EN_OUT;
  endproperty
  a_ignore: assert property (p_ignore) else $error("output dropped in ignore mode");

  property p_delay_on;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == IFR_RUN && fault_act && cfg_ff.mode == IFR_MODE_DELAY && ON_CMD_IN
     && !clear_evt) |=> (state_ff == IFR_DELAY && OUT_EN_OUT);
  endproperty
  a_delay_on: assert property (p_delay_on) else $error("delay mode stopped output");

  property p_disable_now;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == IFR_RUN && fault_act && cfg_ff.mode[1] && ON_CMD_IN && !clear_evt)
    |=> !OUT_EN_OUT;
  endproperty
  a_disable_now: assert property (p_disable_now) else $error("output not disabled");

  property p_latch_mode;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == IFR_RUN && fault_act && cfg_ff.mode == IFR_MODE_LATCH && ON_CMD_IN
     && !clear_evt) |=> FAULT_LATCHED_OUT ##1 (FAULT_LATCHED_OUT || $past(clear_evt || !ON_CMD_IN));
  endproperty
  a_latch_mode: assert property (p_latch_mode) else $error("latch mode not held");

  property p_clear;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    clear_evt |=> (!FAULT_LATCHED_OUT && state_ff == IFR_RUN);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not release fault");

  property p_no_retry;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == IFR_RUN && fault_act && cfg_ff.mode == IFR_MODE_RETRY
     && cfg_ff.retries == IFR_RETRY_NONE && ON_CMD_IN && !clear_evt) |=> FAULT_LATCHED_OUT;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retried with count zero");

  property p_limit;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == IFR_RETRY && nxt_state == IFR_LATCHED) |-> (attempts_ff == 3'h0);
  endproperty
  a_limit: assert property (p_limit) else $error("latched with attempts left");

  property p_unlimited;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (state_ff == IFR_RETRY && cfg_ff.retries == IFR_RETRY_CONT) |=> !FAULT_LATCHED_OUT;
  endproperty
  a_unlimited: assert property (p_unlimited) else $error("continuous retry gave up");

  property p_timer;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (timer_done && state_ff != IFR_LATCHED) |=> (unit_cnt_ff == 8'h00);
  endproperty
  a_timer: assert property (p_timer) else $error("delay ended at wrong count");

  property p_reload;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (clear_evt && !WR_STB_IN) |=> (attempts_ff == cfg_ff.retries);
  endproperty
  a_reload: assert property (p_reload) else $error("attempts not reloaded");

  c_latched:   cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
                               state_ff == IFR_RETRY ##1 state_ff == IFR_LATCHED);
  c_recovered: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
                               state_ff == IFR_RETRY ##1 state_ff == IFR_RUN);
  c_delay_end: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
                               state_ff == IFR_DELAY && timer_done);
endmodule // ifr_top

//--- tb/ifr_host_model.sv
// host model: pmbus byte writes and reads of the action byte, fault clears
// assumes requests change 1 ns after a rising edge of clk
`timescale 1ns/100ps
module ifr_host_model
  import ifr_pkg::*;
(
  // clock
  input  wire logic       clk,
  // byte port toward the responder
  output logic      [7:0] cmd_code,
  output logic            wr_stb,
  output logic      [7:0] wr_data,
  input  wire logic [7:0] rd_data,
  // status clear
  output logic            clear
);
  // idle values at time zero
  initial
  begin
    cmd_code = 8'h00;
    wr_stb   = 1'b0;
    wr_data  = 8'h00;
    clear    = 1'b0;
  end

  // one byte write, data line turned over once released
  task automatic write_byte(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk) #1;
    cmd_code = code;
    wr_stb   = 1'b1;
    wr_data  = data;
    @(posedge clk) #1;
    wr_stb   = 1'b0;
    wr_data  = ~data;
  endtask

  // read: readback is registered, but wait two edges past the code
  task automatic read_byte(input logic [7:0] code, output logic [7:0] data);
    @(posedge clk) #1;
    cmd_code = code;
    @(posedge clk) #1;
    @(posedge clk) #1;
    data = rd_data;
  endtask

  // one-cycle clear-faults pulse
  task automatic clear_faults();
    @(posedge clk) #1;
    clear = 1'b1;
    @(posedge clk) #1;
    clear = 1'b0;
  endtask
endmodule // ifr_host_model

//--- tb/tb_top.sv
// self-checking bench for the input overvoltage fault responder
// assumes the host model drives the byte port and clear pulse
`timescale 1ns/100ps
module tb_top;
  import ifr_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       fault = 1'b0;
  logic       tick = 1'b0;
  logic       on_cmd = 1'b1;
  logic [7:0] cmd, wdata, rdata, rd;
  logic       stb, clr, out_en, latched, prev_en;
  int         mismatches = 0, num_checks = 0, cycles = 0, rises = 0, r0;

  // 125 MHz clock
  always #4 clk = ~clk;

  ifr_top ifr_top_inst (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_CODE_IN(cmd),
    .WR_STB_IN(stb), .WR_DATA_IN(wdata), .RD_DATA_OUT(rdata), .FAULT_IN(fault),
    .UNIT_TICK_IN(tick), .CLEAR_IN(clr), .ON_CMD_IN(on_cmd), .OUT_EN_OUT(out_en),
    .FAULT_LATCHED_OUT(latched));
  ifr_host_model ifr_host_model_inst (.clk(clk), .cmd_code(cmd), .wr_stb(stb),
    .wr_data(wdata), .rd_data(rdata), .clear(clr));

  // counts restarts of the output and cuts a hang short
  always @(posedge clk)
  begin
    #1;
    if (out_en === 1'b1 && prev_en === 1'b0) rises++;
    prev_en = out_en;
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk) #1;
  endtask

  // one delay unit: single-cycle tick then two idle cycles
  task automatic unit();
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(2);
  endtask

  task automatic cfg(input logic [1:0] m, input logic [2:0] r, input logic [2:0] d);
    ifr_host_model_inst.write_byte(IFR_ACTION_ADDR, {m, r, d});
    cyc(1);
  endtask

  // fault gone, latch cleared, output back on
  task automatic recover();
    fault = 1'b0;
    ifr_host_model_inst.clear_faults();
    cyc(3);
    check({6'h0, latched, out_en}, 8'h01);
  endtask

  task automatic test_regs();
    ifr_host_model_inst.read_byte(IFR_ACTION_ADDR, rd);
    check(rd, IFR_ACTION_RST);
    ifr_host_model_inst.write_byte(IFR_ACTION_ADDR, 8'h8A);
    ifr_host_model_inst.write_byte(8'h55, 8'hFF);
    ifr_host_model_inst.read_byte(8'h55, rd);
    check(rd, 8'h00);
    ifr_host_model_inst.read_byte(IFR_ACTION_ADDR, rd);
    check(rd, 8'h8A);
  endtask

  task automatic test_ignore_and_latch();
    cfg(IFR_MODE_IGNORE, 3'h0, 3'h0);
    fault = 1'b1;
    repeat (4) unit();
    check({6'h0, latched, out_en}, 8'h01);
    fault = 1'b0;
    cfg(IFR_MODE_LATCH, 3'h3, 3'h0);
    fault = 1'b1;
    cyc(2);
    check({6'h0, latched, out_en}, 8'h02);
    repeat (6) unit();
    check({6'h0, latched, out_en}, 8'h02);
    recover();
  endtask

  // each limited retry setting (0 to 6, 7 replaced by 2) with a fault that never goes away
  task automatic test_retry_counts();
    logic [2:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r = (i == 7) ? 3'h2 : i[2:0];
      cfg(IFR_MODE_RETRY, r, 3'h0);
      r0 = rises;
      fault = 1'b1;
      repeat (16) unit();
      check(8'(rises - r0), {5'h0, r});
      check({6'h0, latched, out_en}, 8'h02);
      recover();
    end
  endtask

  task automatic test_unlimited();
    cfg(IFR_MODE_RETRY, IFR_RETRY_CONT, 3'h0);
    r0 = rises;
    fault = 1'b1;
    repeat (16) unit();
    check({7'h0, (rises - r0) > 6}, 8'h01);
    check({7'h0, latched}, 8'h00);
    on_cmd = 1'b0;
    cyc(2);
    check({7'h0, out_en}, 8'h00);
    fault = 1'b0;
    on_cmd = 1'b1;
    cyc(3);
    check({6'h0, latched, out_en}, 8'h01);
  endtask

  task automatic test_delays();
    cfg(IFR_MODE_RETRY, 3'h1, 3'h2);
    fault = 1'b1;
    cyc(2);
    check({7'h0, out_en}, 8'h00);
    repeat (3) unit();
    check({7'h0, out_en}, 8'h00);
    // the attempt opens on the fourth tick; the fault ends it a cycle later
    tick = 1'b1;
    cyc(1);
    check({7'h0, out_en}, 8'h01);
    tick = 1'b0;
    cyc(2);
    recover();
    cfg(IFR_MODE_DELAY, 3'h0, 3'h1);
    fault = 1'b1;
    // the tick that meets fault detection is not counted
    unit();
    check({6'h0, latched, out_en}, 8'h01);
    unit();
    check({6'h0, latched, out_en}, 8'h01);
    unit();
    check({6'h0, latched, out_en}, 8'h02);
    recover();
  endtask

  initial
  begin
    cyc(16);
    rst_n = 1'b1;
    cyc(2);
    test_regs();
    test_ignore_and_latch();
    test_retry_counts();
    test_unlimited();
    test_delays();
    tally_and_finish();
  end
endmodule // tb_top
